//--- hdl/adcsq_pkg.sv
// types shared by the converter control block
package adcsq_pkg;
	typedef enum logic [1:0] {
		ADCSQ_IDLE = 2'b00,
		ADCSQ_CONV = 2'b01,
		ADCSQ_DONE = 2'b11
	} adcsq_state_e;
	typedef struct packed {
		logic       start;
		logic       input_disable;
		logic [3:0] channel;
	} adcsq_ctrl_a_s;
	typedef struct packed {
		logic       ladder;
		logic [2:0] time_sel;
	} adcsq_ctrl_b_s;
endpackage

//--- hdl/adcsq_regs.svh
// register map, field positions, reset values and timing counts
// Functional notes
// R1: start bit launches conversion, self-clears
// R2: software sets disable when inputs unused
// R3: channel codes 2..5 valid, reset reserved
// R4: change channel only while not busy
// R5: no restart during conversion
// R6: stop mode initializes controls, blocks writes
// R7: control a bit5 one, bit6 zero
// R8: control b bit0 zero, bit4 one
// R9: time codes give 78..1248 fc periods
// R10: avoid inhibited times, keep 15.6us minimum
// R11: control b bits 7:6 read undefined
// R12: result read-only, resets to zero
// R13: state bit5 is done flag
// R14: result read clears done flag
// R15: read state before result
// R16: busy set at start, cleared end/stop
// R17: state other bits read meaningless
// R18: avoid port output during conversion
// R19: completion stores result, sets done, irq
// R20: restart clears done, keeps old result
// R21: stop aborts, result lost, ladder off
// R22: ladder bit selects always-on connection
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH
`define ADCSQ_IDX_CTRL_A   10'h00E
`define ADCSQ_IDX_CTRL_B   10'h00F
`define ADCSQ_IDX_RESULT   10'h020
`define ADCSQ_IDX_STATE    10'h021
`define ADCSQ_RST_CTRL_A   8'h10
`define ADCSQ_RST_CTRL_B   8'h10
`define ADCSQ_RST_RESULT   8'h00
`define ADCSQ_BIT_START    7
`define ADCSQ_BIT_DONE     5
`define ADCSQ_BIT_BUSY     4
`define ADCSQ_BIT_LADDER   5
`define ADCSQ_BIT_DISABLE  4
`define ADCSQ_BIT_ONE_A    5
`define ADCSQ_BIT_ONE_B    4
`define ADCSQ_CH_MSB       3
`define ADCSQ_TIME_MSB     3
`define ADCSQ_TIME_LSB     1
`define ADCSQ_CH_FIRST     4'h2
`define ADCSQ_CH_LAST      4'h5
`define ADCSQ_CYC_BASE     78
`define ADCSQ_ACK_FIRST    3'h2
`define ADCSQ_ACK_LAST     3'h6
`define ADCSQ_FILL         8'h00
`endif

//--- hdl/adcsq_top.sv
// apb register file and conversion sequencer of the 8-bit converter
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "adcsq_regs.svh"
module adcsq_top
	import adcsq_pkg::*;
#(
	parameter int FC_DIV = 1
)
(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_stop_mode,
	input  wire logic [11:0] i_paddr,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic [7:0]  i_sar_data,
	output logic             o_sample,
	output logic [1:0]       o_channel,
	output logic             o_channel_valid,
	output logic             o_input_disable,
	output logic             o_ladder_on,
	output logic             o_conversion_done_irq
);
	// the dividers count in 16 bits
	generate
		if (FC_DIV < 1)
		begin : g_div_low
			$error("FC_DIV must be at least 1");
		end
		if (FC_DIV > 65535)
		begin : g_div_high
			$error("FC_DIV must fit in 16 bits");
		end
	endgenerate

	// reset images of the two control registers
	localparam logic [7:0] RST_A = `ADCSQ_RST_CTRL_A;
	localparam logic [7:0] RST_B = `ADCSQ_RST_CTRL_B;
	localparam adcsq_ctrl_a_s INIT_A = '{
		start:         RST_A[`ADCSQ_BIT_START],
		input_disable: RST_A[`ADCSQ_BIT_DISABLE],
		channel:       RST_A[`ADCSQ_CH_MSB:0]
	};
	localparam adcsq_ctrl_b_s INIT_B = '{
		ladder:   RST_B[`ADCSQ_BIT_LADDER],
		time_sel: RST_B[`ADCSQ_TIME_MSB:`ADCSQ_TIME_LSB]
	};

	adcsq_state_e   state;
	adcsq_state_e   next_state;
	adcsq_ctrl_a_s  ctrl_a;
	adcsq_ctrl_b_s  ctrl_b;
	logic [7:0]     result;
	logic           done;
	logic [15:0]    cyc_cnt;
	logic [15:0]    fc_cnt;
	logic [7:0]     rdata;

	// apb decode: each register holds one aligned word
	function automatic logic reg_hit(input logic [11:0] addr,
	                                 input logic [9:0]  idx);
		return addr == {idx, 2'b00};
	endfunction

	wire acc      = i_psel & i_penable;
	wire wr       = acc & i_pwrite;
	wire rd       = acc & ~i_pwrite;
	wire sel_a    = reg_hit(i_paddr, `ADCSQ_IDX_CTRL_A);
	wire sel_b    = reg_hit(i_paddr, `ADCSQ_IDX_CTRL_B);
	wire sel_res  = reg_hit(i_paddr, `ADCSQ_IDX_RESULT);
	wire sel_st   = reg_hit(i_paddr, `ADCSQ_IDX_STATE);
	wire mapped   = sel_a | sel_b | sel_res | sel_st;
	wire busy     = state == ADCSQ_CONV;

	// stop mode refuses control writes
	wire wr_a     = wr & sel_a & ~i_stop_mode; // see R6
	wire wr_b     = wr & sel_b & ~i_stop_mode; // see R6
	wire start_go = ctrl_a.start & ~busy & ~i_stop_mode; // see R1

	// one tick per fc period
	wire fc_tick  = fc_cnt == 16'(FC_DIV - 1);

	// conversion length in fc periods
	function automatic logic [15:0] conv_len(input logic [2:0] sel);
		logic [15:0] len;
		len = 16'(`ADCSQ_CYC_BASE);
		if (sel >= `ADCSQ_ACK_FIRST && sel <= `ADCSQ_ACK_LAST)
			len = 16'(`ADCSQ_CYC_BASE) << (sel - `ADCSQ_ACK_FIRST); // see R9
		return len;
	endfunction

	// valid channel codes form one contiguous range
	function automatic logic chan_valid(input logic [3:0] code);
		return code >= `ADCSQ_CH_FIRST && code <= `ADCSQ_CH_LAST;
	endfunction

	// conversion length and its final fc period
	wire [15:0] len_now = conv_len(ctrl_b.time_sel);
	wire last_cyc = fc_tick && cyc_cnt == len_now - 16'd1;
	wire chan_ok = chan_valid(ctrl_a.channel); // see R3

	always_comb
	begin
		next_state = state;
		case (state)
			ADCSQ_IDLE, ADCSQ_DONE:
				if (start_go)
					next_state = ADCSQ_CONV;
			ADCSQ_CONV:
				if (i_stop_mode)
					next_state = ADCSQ_IDLE; // see R21
				else if (last_cyc)
					next_state = ADCSQ_DONE; // see R19
			default:
				next_state = ADCSQ_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			state <= ADCSQ_IDLE;
		else
			state <= next_state; // see R16
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			fc_cnt <= 16'h0000;
		else if (!busy || fc_tick)
			fc_cnt <= 16'h0000;
		else
			fc_cnt <= fc_cnt + 16'd1;
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			cyc_cnt <= 16'h0000;
		else if (!busy)
			cyc_cnt <= 16'h0000;
		else if (fc_tick)
			cyc_cnt <= cyc_cnt + 16'd1;
	end

	// stop mode holds both controls at their reset images
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			ctrl_a <= INIT_A;
		else if (i_stop_mode)
			ctrl_a <= INIT_A; // see R6
		else if (wr_a)
			ctrl_a <= {i_pwdata[`ADCSQ_BIT_START],
			           i_pwdata[`ADCSQ_BIT_DISABLE:0]};
		else if (start_go)
			ctrl_a.start <= 1'b0; // see R1
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			ctrl_b <= INIT_B;
		else if (i_stop_mode)
			ctrl_b <= INIT_B; // see R6
		else if (wr_b)
			ctrl_b <= {i_pwdata[`ADCSQ_BIT_LADDER],
			           i_pwdata[`ADCSQ_TIME_MSB:`ADCSQ_TIME_LSB]};
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			result <= `ADCSQ_RST_RESULT; // see R12
		else if (i_stop_mode && busy)
			result <= `ADCSQ_RST_RESULT; // see R21
		else if (busy && last_cyc)
			result <= i_sar_data; // see R19 R20
	end

	// completion wins over a clearing read in the same cycle
	wire done_set = busy & last_cyc & ~i_stop_mode;
	wire done_clr = start_go | (rd & sel_res);

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			done <= 1'b0;
		else if (done_set)
			done <= 1'b1; // see R13 R19
		else if (done_clr)
			done <= 1'b0; // see R14 R20
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_conversion_done_irq <= 1'b0;
		else
			o_conversion_done_irq <= done_set; // see R19
	end

	// control a image: fixed one in its marker bit
	function automatic logic [7:0] view_a(input adcsq_ctrl_a_s c);
		logic [7:0] v;
		v = `ADCSQ_FILL;
		v[`ADCSQ_BIT_START]   = c.start;
		v[`ADCSQ_BIT_ONE_A]   = 1'b1;
		v[`ADCSQ_BIT_DISABLE] = c.input_disable;
		v[`ADCSQ_CH_MSB:0]    = c.channel;
		return v;
	endfunction

	// control b image: undefined top bits read as fill
	function automatic logic [7:0] view_b(input adcsq_ctrl_b_s c);
		logic [7:0] v;
		v = `ADCSQ_FILL; // see R11
		v[`ADCSQ_BIT_LADDER] = c.ladder;
		v[`ADCSQ_BIT_ONE_B]  = 1'b1;
		v[`ADCSQ_TIME_MSB:`ADCSQ_TIME_LSB] = c.time_sel;
		return v;
	endfunction

	// status image: only done and busy carry meaning
	function automatic logic [7:0] view_state(input logic d,
	                                          input logic b);
		logic [7:0] v;
		v = `ADCSQ_FILL; // see R17
		v[`ADCSQ_BIT_DONE] = d; // see R13
		v[`ADCSQ_BIT_BUSY] = b; // see R16
		return v;
	endfunction

	// read mux, launched into prdata in the setup cycle
	always_comb
	begin
		rdata = `ADCSQ_FILL;
		if (sel_a)
			rdata = view_a(ctrl_a);
		else if (sel_b)
			rdata = view_b(ctrl_b); // see R11
		else if (sel_res)
			rdata = result; // see R12
		else if (sel_st)
			rdata = view_state(done, busy); // see R17
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_prdata <= 32'h0000_0000;
		else if (i_psel && !i_penable && !i_pwrite)
			o_prdata <= {24'h00_0000, rdata};
	end

	// analog side follows the controls one cycle late
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_channel <= 2'b00;
		else
			o_channel <= 2'(ctrl_a.channel - `ADCSQ_CH_FIRST);
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_channel_valid <= 1'b0;
		else
			o_channel_valid <= chan_ok; // see R3
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_input_disable <= 1'b0;
		else
			o_input_disable <= ctrl_a.input_disable;
	end

	// ladder dropped in stop mode, held on while busy or forced
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_ladder_on <= 1'b0;
		else
			o_ladder_on <= (ctrl_b.ladder | busy) & ~i_stop_mode; // see R22 R21
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_sample <= 1'b0;
		else
			o_sample <= busy;
	end

	assign o_pready  = 1'b1;
	assign o_pslverr = acc & ~mapped;
endmodule

//--- tb/adcsq_source.sv
// analog sources on the shared input pins
`timescale 1ns/10ps
module adcsq_source
(
	input logic	i_clk,
	input logic	i_sample,
	input logic [1:0]	i_channel,
	output logic [7:0]	o_data
);
	always_ff @(posedge i_clk)
		o_data <= i_sample ? {6'h2C, i_channel} : ~o_data;
endmodule

//--- tb/adcsq_sva.sv
// converter control checker
`timescale 1ns/10ps
module adcsq_sva
(
	input logic	i_clk,
	input logic	i_reset_n,
	input logic	i_stop_mode,
	input logic [11:0]	i_paddr,
	input logic	i_psel,
	input logic	i_penable,
	input logic	i_pwrite,
	input logic [31:0]	i_pwdata,
	input logic [31:0]	o_prdata,
	input logic	o_sample,
	input logic	o_ladder_on,
	input logic	o_conversion_done_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire rd = i_psel && i_penable && !i_pwrite;
	wire irq = o_conversion_done_irq;
	sequence s_start;
		i_psel && i_penable && i_pwrite && i_paddr == 12'h038 &&
		i_pwdata[7] && !i_stop_mode;
	endsequence
	a_busy_up: assert property (s_start |-> ##[1:4] o_sample)
		else $error("no busy");
	a_busy_drop: assert property (i_stop_mode [*2] |=> !o_sample)
		else $error("busy");
	a_ladder_off: assert property (i_stop_mode |=> !o_ladder_on)
		else $error("ladder");
	a_ladder_busy:
		assert property (o_sample && !$past(i_stop_mode) |-> o_ladder_on)
		else $error("no ladder");
	a_irq_pulse: assert property (irq |=> !irq)
		else $error("irq long");
	a_irq_cause: assert property (irq |-> $past(o_sample))
		else $error("irq idle");
	a_ctlb_bits:
		assert property (rd && i_paddr == 12'h03C |-> o_prdata[7:6] == 0)
		else $error("ctlb");
	a_state_bits:
		assert property (rd && i_paddr == 12'h084 |-> o_prdata[3:0] == 0)
		else $error("state");
endmodule

//--- tb/testbench.sv
// converter control bench
`timescale 1ns/10ps
module testbench;
	logic	i_clk = 0, i_reset_n = 0, i_stop_mode = 0, i_psel = 0;
	logic	i_penable = 0, i_pwrite = 0, o_pready, o_pslverr;
	logic	o_sample, o_channel_valid, o_input_disable, o_ladder_on;
	logic	o_conversion_done_irq;
	logic [11:0]	i_paddr = 0;
	logic [31:0]	i_pwdata = 0, o_prdata;
	logic [7:0]	i_sar_data;
	logic [1:0]	o_channel;
	int	error_cnt = 0, num_checks = 0, cyc = 0;
	always #2.5 i_clk = ~i_clk;
	adcsq_top adcsq_top_i (.*);
	adcsq_source adcsq_source_i (.i_clk, .i_sample(o_sample),
		.i_channel(o_channel), .o_data(i_sar_data));
	task stop_test(input int hang);
		error_cnt += hang;
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, e);
		num_checks++;
		error_cnt += s !== e;
		if (s !== e)
			$display("[ERR] %0t %h %h", $time, s, e);
	endtask
	task apb(input logic w, logic [11:0] a, logic [7:0] d);
		@(posedge i_clk);
		i_psel <= 1;
		{i_pwrite, i_paddr, i_pwdata} <= {w, a, 24'h0, d};
		@(posedge i_clk);
		i_penable <= 1;
		@(posedge i_clk iff o_pready === 1);
		chk(o_pslverr, a == 12'h004);
		if (!w)
			chk(o_prdata, {24'h0, d});
		{i_psel, i_penable} <= 2'b0;
	endtask
	task t_conv;
		logic [7:0] last = 0;
		int t0;
		for (int i = 0; i < 5; i++)
		begin
			apb(1, 12'h03C, {2'b0, i[0], 1'b1, 3'(i + 2), 1'b0});
			apb(1, 12'h038, 8'hA2 + 8'(i % 4));
			t0 = cyc + (78 << i);
			apb(0, 12'h084, 8'h10);
			apb(0, 12'h080, last);
			@(negedge i_clk);
			chk(o_ladder_on, 1);
			chk(o_channel_valid, 1);
			chk(o_input_disable, 0);
			wait (o_conversion_done_irq === 1);
			@(negedge i_clk);
			chk(cyc - t0 inside {[0:5]}, 1);
			@(negedge i_clk);
			chk(o_conversion_done_irq, 0);
			chk(o_ladder_on, i[0]);
			last = 8'hB0 + 8'(i % 4);
			apb(0, 12'h084, 8'h20);
			apb(0, 12'h038, 8'h22 + 8'(i % 4));
		end
		apb(0, 12'h080, last);
		apb(0, 12'h084, 8'h00);
	endtask
	task t_stop;
		apb(1, 12'h038, 8'hA3);
		repeat (20) @(posedge i_clk);
		i_stop_mode <= 1;
		apb(1, 12'h038, 8'h25);
		apb(0, 12'h038, 8'h30);
		apb(0, 12'h03C, 8'h10);
		apb(0, 12'h080, 8'h00);
		apb(0, 12'h084, 8'h00);
		apb(0, 12'h004, 8'h00);
		@(negedge i_clk);
		chk(o_ladder_on, 0);
		chk(o_channel_valid, 0);
		chk(o_input_disable, 1);
		@(posedge i_clk);
		i_stop_mode <= 0;
		apb(1, 12'h038, 8'h33);
		apb(0, 12'h038, 8'h33);
		apb(0, 12'h084, 8'h00);
	endtask
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_reset_n <= 1;
		t_conv;
		t_stop;
		stop_test(0);
	end
	always @(posedge i_clk)
		if (++cyc > 9000)
			stop_test(1);
endmodule
bind adcsq_top adcsq_sva adcsq_sva_i (.*);
